// File: phy_lp_pkg.sv
`default_nettype none
package phy_lp_pkg;
   // management register numbers
   localparam logic [4:0]  REG_BASIC_CTRL   = 5'h00;
   localparam logic [4:0]  REG_DIG_CTRL     = 5'h10;
   localparam logic [4:0]  REG_OSC_CTRL     = 5'h11;
   localparam logic [4:0]  REG_SENSE_CTRL   = 5'h18;
   localparam logic [4:0]  REG_PHY_CTRL2    = 5'h1f;
   // field positions
   localparam int          BIT_SW_RESET     = 15;
   localparam int          BIT_POWER_DOWN   = 11;
   localparam int          BIT_PLL_AUTO_OFF = 4;
   localparam int          BIT_SLOW_OSC     = 5;
   localparam int          BIT_SLEEP_DIS_N  = 11;
   localparam int          BIT_PSAVE_EN     = 10;
   // reset values of the held bits
   localparam logic        RST_POWER_DOWN   = 1'b0;
   localparam logic        RST_PLL_AUTO_OFF = 1'b0;
   localparam logic        RST_SLOW_OSC     = 1'b0;
   localparam logic        RST_SLEEP_DIS_N  = 1'b1;
   localparam logic        RST_PSAVE_EN     = 1'b0;
   // timing
   localparam int          CLOCK_MHZ        = 250;
   localparam int          PULSE_GAP_US     = 16000;
   localparam int          PULSE_GAP_CYC    = PULSE_GAP_US * CLOCK_MHZ;
   localparam int          LONG_GAP_MULT    = 4;
   localparam int          WAKE_HOLD_US     = 2000;
   localparam int          WAKE_HOLD_CYC    = WAKE_HOLD_US * CLOCK_MHZ;
   // power modes
   typedef enum logic [1:0] {
      MODE_ACTIVE,
      MODE_PSAVE,
      MODE_SLEEP,
      MODE_PDOWN
   } lp_mode_t;
endpackage
`default_nettype wire

// File: pwr_regs_if.sv
`timescale 1ns/1ps
`default_nettype none
// held low-power control bits, register bank to mode controller
interface pwr_regs_if;
   logic power_down;   // basic control power-down bit
   logic sw_reset;     // basic control reset bit, self-clearing
   logic pll_auto_off; // pll off while asleep
   logic slow_osc;     // slow oscillator select
   logic sleep_dis_n;  // active low sleep enable bit
   logic psave_en;     // power-saving enable
   modport regs (output power_down, sw_reset, pll_auto_off, slow_osc, sleep_dis_n, psave_en);
   modport ctrl (input  power_down, sw_reset, pll_auto_off, slow_osc, sleep_dis_n, psave_en);
endinterface
`default_nettype wire

// File: lp_mgmt_regs.sv
`timescale 1ns/1ps
`default_nettype none
// holds the low-power bits written over the management port
module lp_mgmt_regs (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_wr_en,
   input  wire logic [4:0]  i_wr_reg,
   input  wire logic [15:0] i_wr_data,
   pwr_regs_if.regs         bits
);
   import phy_lp_pkg::*;

   logic power_down, next_power_down;
   logic pll_auto_off, next_pll_auto_off;
   logic slow_osc, next_slow_osc;
   logic sleep_dis_n, next_sleep_dis_n;
   logic psave_en, next_psave_en;
   logic rst_pend, next_rst_pend; // reset bit, clears itself next cycle

   // write decode; a pending soft reset reloads defaults
   always_comb begin
      next_power_down   = power_down;
      next_pll_auto_off = pll_auto_off;
      next_slow_osc     = slow_osc;
      next_sleep_dis_n  = sleep_dis_n;
      next_psave_en     = psave_en;
      next_rst_pend     = 1'b0;
      if (rst_pend) begin
         // writes in the reset cycle are dropped on purpose
         next_power_down   = RST_POWER_DOWN;
         next_pll_auto_off = RST_PLL_AUTO_OFF;
         next_slow_osc     = RST_SLOW_OSC;
         next_sleep_dis_n  = RST_SLEEP_DIS_N;
         next_psave_en     = RST_PSAVE_EN;
      end else if (i_wr_en) begin
         case (i_wr_reg)
            REG_BASIC_CTRL: begin
               next_power_down = i_wr_data[BIT_POWER_DOWN];
               next_rst_pend   = i_wr_data[BIT_SW_RESET];
            end
            REG_DIG_CTRL:   next_pll_auto_off = i_wr_data[BIT_PLL_AUTO_OFF];
            REG_OSC_CTRL:   next_slow_osc     = i_wr_data[BIT_SLOW_OSC];
            REG_SENSE_CTRL: next_sleep_dis_n  = i_wr_data[BIT_SLEEP_DIS_N];
            REG_PHY_CTRL2:  next_psave_en     = i_wr_data[BIT_PSAVE_EN];
            default: ;
         endcase
      end
   end

   // power-up values: both sleep modes off
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         power_down   <= RST_POWER_DOWN;
         pll_auto_off <= RST_PLL_AUTO_OFF;
         slow_osc     <= RST_SLOW_OSC;
         sleep_dis_n  <= RST_SLEEP_DIS_N;
         psave_en     <= RST_PSAVE_EN;
         rst_pend     <= 1'b0;
      end else begin
         power_down   <= next_power_down;
         pll_auto_off <= next_pll_auto_off;
         slow_osc     <= next_slow_osc;
         sleep_dis_n  <= next_sleep_dis_n;
         psave_en     <= next_psave_en;
         rst_pend     <= next_rst_pend;
      end
   end

   assign bits.power_down   = power_down;
   assign bits.sw_reset     = rst_pend;
   assign bits.pll_auto_off = pll_auto_off;
   assign bits.slow_osc     = slow_osc;
   assign bits.sleep_dis_n  = sleep_dis_n;
   assign bits.psave_en     = psave_en;
endmodule
`default_nettype wire

// File: lp_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
// periodic one-cycle pulse while enabled; gap optionally stretched
module lp_pulse_timer #(
   parameter int GAP_CYCLES = 16,
   parameter int LONG_MULT  = 4
) (
   input  wire logic i_clock,
   input  wire logic i_rst_n,
   input  wire logic i_enable,
   input  wire logic i_long_gap,
   output var  logic o_pulse
);
   localparam int CW = $clog2(GAP_CYCLES * LONG_MULT + 1);
   localparam logic [CW-1:0] SHORT_LOAD = CW'(GAP_CYCLES - 1);
   localparam logic [CW-1:0] LONG_LOAD  = CW'(GAP_CYCLES * LONG_MULT - 1);

   logic [CW-1:0] count, next_count; // cycles left to next pulse
   logic          next_pulse;

   // first pulse right after enable, so a partner sees us at once
   always_comb begin
      next_count = count;
      next_pulse = 1'b0;
      if (!i_enable) begin
         next_count = '0;
      end else if (count == '0) begin
         next_pulse = 1'b1;
         next_count = i_long_gap ? LONG_LOAD : SHORT_LOAD;
      end else begin
         next_count = count - CW'(1);
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count   <= '0;
         o_pulse <= 1'b0;
      end else begin
         count   <= next_count;
         o_pulse <= next_pulse;
      end
   end
endmodule
`default_nettype wire

// File: phy_low_power_mode_control.sv
// Behaviour
// - ctrl2 bit 10 enables power-saving when unlinked
// - power-saving keeps transmitter, energy detect, pll
// - power-saving disabled after power-up
// - reg 18h bit 11 low enables sleep
// - reg 10h bit 4 turns pll off asleep
// - energy sense sleep disabled after power-up
// - sleep keeps sending link pulses, gap stretchable
// - basic bit 11 powers down all but management
// - clearing basic bit 11 leaves power-down
// - reg 11h bit 5 selects slow oscillator
// - slow oscillator plus power-down gives lowest power
// - all low-power bits readable and writable
`timescale 1ns/1ps
`default_nettype none
module phy_low_power_mode_control #(
   parameter int PULSE_GAP_CYCLES = phy_lp_pkg::PULSE_GAP_CYC,
   parameter int LONG_GAP_FACTOR  = phy_lp_pkg::LONG_GAP_MULT,
   parameter int WAKE_HOLD_CYCLES = phy_lp_pkg::WAKE_HOLD_CYC
) (
   input  wire logic                 i_clock,
   input  wire logic                 i_rst_n,
   // management register port
   input  wire logic                 i_wr_en,
   input  wire logic [4:0]           i_wr_reg,
   input  wire logic [15:0]          i_wr_data,
   input  wire logic [4:0]           i_rd_reg,
   output var  logic [15:0]          o_rd_data,
   // line and negotiation status
   input  wire logic                 i_autoneg_en,
   input  wire logic                 i_link_up,
   input  wire logic                 i_energy_detect,
   input  wire logic                 i_long_pulse_gap,
   // power controls toward the transceiver
   output var  logic                 o_rx_blocks_en,
   output var  logic                 o_tx_en,
   output var  logic                 o_energy_det_en,
   output var  logic                 o_pll_en,
   output var  logic                 o_ref_crystal_input_en,
   output var  logic                 o_slow_osc_sel,
   output var  logic                 o_mgmt_only,
   output var  logic                 o_lowest_power,
   output var  logic                 o_link_pulse,
   output var  logic                 o_soft_reset,
   output var  phy_lp_pkg::lp_mode_t o_mode
);
   import phy_lp_pkg::*;

   localparam int WW = $clog2(WAKE_HOLD_CYCLES + 1);
   localparam logic [WW-1:0] WAKE_LOAD = WW'(WAKE_HOLD_CYCLES);

   pwr_regs_if bits ();                // held bits from the register bank

   lp_mode_t   mode, next_mode;        // current power mode
   logic [WW-1:0] wake_cnt, next_wake_cnt; // hold-off after line energy
   logic       eligible;               // unlinked and negotiating
   logic       pulse;                  // link pulse from timer
   logic       next_rx_blocks_en;
   logic       next_tx_en;
   logic       next_energy_det_en;
   logic       next_pll_en;
   logic       next_ref_en;
   logic       next_slow_sel;
   logic       next_mgmt_only;
   logic       next_lowest;
   logic [15:0] next_rd_data;

   // register bank: writes, defaults, self-clearing reset bit
   lp_mgmt_regs u_regs (
      .i_clock   (i_clock),
      .i_rst_n   (i_rst_n),
      .i_wr_en   (i_wr_en),
      .i_wr_reg  (i_wr_reg),
      .i_wr_data (i_wr_data),
      .bits      (bits)
   );

   // link pulses only while asleep
   lp_pulse_timer #(
      .GAP_CYCLES (PULSE_GAP_CYCLES),
      .LONG_MULT  (LONG_GAP_FACTOR)
   ) u_pulse (
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_enable   (mode == MODE_SLEEP),
      .i_long_gap (i_long_pulse_gap),
      .o_pulse    (pulse)
   );

   // the two reduced modes need negotiation on and no link
   assign eligible = i_autoneg_en && !i_link_up && (wake_cnt == '0);

   // mode choice; power-down outranks both energy-sensing modes
   always_comb begin
      next_wake_cnt = wake_cnt;
      // line energy while reduced or waking: hold blocks up for negotiation;
      // energy keeps reloading the hold so negotiation is not cut off mid-way
      if (i_link_up || !i_autoneg_en) begin
         next_wake_cnt = '0;
      end else if ((mode == MODE_PSAVE || mode == MODE_SLEEP || wake_cnt != '0)
                   && i_energy_detect) begin
         next_wake_cnt = WAKE_LOAD;
      end else if (wake_cnt != '0) begin
         next_wake_cnt = wake_cnt - WW'(1);
      end
      if (bits.sw_reset) begin
         next_mode     = MODE_ACTIVE;
         next_wake_cnt = '0;
      end else if (bits.power_down) begin
         next_mode = MODE_PDOWN;
      end else if (next_wake_cnt != '0) begin
         next_mode = MODE_ACTIVE;
      end else if (!bits.sleep_dis_n && eligible) begin
         next_mode = MODE_SLEEP;
      end else if (bits.psave_en && eligible) begin
         next_mode = MODE_PSAVE;
      end else begin
         next_mode = MODE_ACTIVE;
      end
   end

   // block enables follow the next mode so outputs leave flops
   always_comb begin
      next_rx_blocks_en  = 1'b0;
      next_tx_en         = 1'b1;
      next_energy_det_en = 1'b1;
      next_pll_en        = 1'b1;
      next_mgmt_only     = 1'b0;
      case (next_mode)
         MODE_ACTIVE: next_rx_blocks_en = 1'b1;
         MODE_PSAVE: ;
         MODE_SLEEP: next_pll_en = !bits.pll_auto_off;
         MODE_PDOWN: begin
            // only the management port stays alive
            next_tx_en         = 1'b0;
            next_energy_det_en = 1'b0;
            next_pll_en        = 1'b0;
            next_mgmt_only     = 1'b1;
         end
         default: next_rx_blocks_en = 1'b1;
      endcase
      // oscillator swap is independent of mode; reset returns to crystal
      next_slow_sel = bits.slow_osc && !bits.sw_reset;
      next_ref_en   = !next_slow_sel;
      next_lowest   = next_slow_sel && (next_mode == MODE_PDOWN);
   end

   // read-back of every low-power bit; unheld bits read zero
   always_comb begin
      next_rd_data = 16'h0000;
      case (i_rd_reg)
         REG_BASIC_CTRL: begin
            next_rd_data[BIT_POWER_DOWN] = bits.power_down;
            next_rd_data[BIT_SW_RESET]   = bits.sw_reset;
         end
         REG_DIG_CTRL:   next_rd_data[BIT_PLL_AUTO_OFF] = bits.pll_auto_off;
         REG_OSC_CTRL:   next_rd_data[BIT_SLOW_OSC]     = bits.slow_osc;
         REG_SENSE_CTRL: next_rd_data[BIT_SLEEP_DIS_N]  = bits.sleep_dis_n;
         REG_PHY_CTRL2:  next_rd_data[BIT_PSAVE_EN]     = bits.psave_en;
         default: ;
      endcase
   end

   // state and output registers; reset comes up fully active
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode                   <= MODE_ACTIVE;
         wake_cnt               <= '0;
         o_mode                 <= MODE_ACTIVE;
         o_rx_blocks_en         <= 1'b1;
         o_tx_en                <= 1'b1;
         o_energy_det_en        <= 1'b1;
         o_pll_en               <= 1'b1;
         o_ref_crystal_input_en <= 1'b1;
         o_slow_osc_sel         <= 1'b0;
         o_mgmt_only            <= 1'b0;
         o_lowest_power         <= 1'b0;
         o_link_pulse           <= 1'b0;
         o_soft_reset           <= 1'b0;
         o_rd_data              <= 16'h0000;
      end else begin
         mode                   <= next_mode;
         wake_cnt               <= next_wake_cnt;
         o_mode                 <= next_mode;
         o_rx_blocks_en         <= next_rx_blocks_en;
         o_tx_en                <= next_tx_en;
         o_energy_det_en        <= next_energy_det_en;
         o_pll_en               <= next_pll_en;
         o_ref_crystal_input_en <= next_ref_en;
         o_slow_osc_sel         <= next_slow_sel;
         o_mgmt_only            <= next_mgmt_only;
         o_lowest_power         <= next_lowest;
         // timer lags a cycle; gate so no pulse leaks out once sleep ends
         o_link_pulse           <= pulse && (next_mode == MODE_SLEEP);
         o_soft_reset           <= bits.sw_reset;
         o_rd_data              <= next_rd_data;
      end
   end
endmodule
`default_nettype wire

// File: lp_mode_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// watches the low-power controller's ports; mode and enables must follow the held bits
module lp_mode_monitor
   import phy_lp_pkg::*;
#(
   parameter int PULSE_GAP_CYCLES = 20,
   parameter int LONG_GAP_FACTOR  = 4,
   parameter int WAKE_HOLD_CYCLES = 10
) (
   input  wire logic                 i_clock,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_wr_en,
   input  wire logic [4:0]           i_wr_reg,
   input  wire logic [15:0]          i_wr_data,
   input  wire logic                 i_autoneg_en,
   input  wire logic                 i_link_up,
   input  wire logic                 i_energy_detect,
   input  wire logic                 o_rx_blocks_en,
   input  wire logic                 o_tx_en,
   input  wire logic                 o_energy_det_en,
   input  wire logic                 o_pll_en,
   input  wire logic                 o_ref_crystal_input_en,
   input  wire logic                 o_slow_osc_sel,
   input  wire logic                 o_mgmt_only,
   input  wire logic                 o_lowest_power,
   input  wire logic                 o_link_pulse,
   input  wire logic                 o_soft_reset,
   input  wire phy_lp_pkg::lp_mode_t o_mode
);
   logic rst_wr;   // software reset write this cycle
   logic rst_wr_q; // software reset write last cycle
   assign rst_wr = i_wr_en && i_wr_reg == REG_BASIC_CTRL && i_wr_data[BIT_SW_RESET];
   // a write just after a reset write is dropped, so it must not arm the checks
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_wr_q <= 1'b0;
      end else begin
         rst_wr_q <= rst_wr;
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   psave_blocks_a: assert property (
      o_mode == MODE_PSAVE |-> !o_rx_blocks_en && o_tx_en && o_energy_det_en && o_pll_en)
      else $error("power-saving enables wrong");
   unlinked_only_a: assert property (
      o_mode inside {MODE_PSAVE, MODE_SLEEP} |-> $past(i_autoneg_en) && !$past(i_link_up))
      else $error("low-power mode while linked or negotiation off");
   pdown_enter_a: assert property (
      i_wr_en && i_wr_reg == REG_BASIC_CTRL && i_wr_data[BIT_POWER_DOWN] && !rst_wr && !rst_wr_q
      |-> ##2 o_mode == MODE_PDOWN && o_mgmt_only && !o_tx_en && !o_pll_en)
      else $error("power-down not entered");
   pdown_exit_a: assert property (
      o_mode == MODE_PDOWN && i_wr_en && i_wr_reg == REG_BASIC_CTRL
      && !i_wr_data[BIT_POWER_DOWN] && !rst_wr_q |-> ##2 o_mode != MODE_PDOWN && !o_mgmt_only)
      else $error("power-down not left");
   lowest_power_a: assert property (
      o_lowest_power == (o_mgmt_only && o_slow_osc_sel))
      else $error("lowest power flag wrong");
   ref_swap_a: assert property (
      i_wr_en && i_wr_reg == REG_OSC_CTRL && !rst_wr_q
      |-> ##2 o_slow_osc_sel == $past(i_wr_data[BIT_SLOW_OSC], 2)
          && !o_ref_crystal_input_en == o_slow_osc_sel)
      else $error("oscillator select wrong");
   soft_reset_a: assert property (
      rst_wr && !rst_wr_q |-> ##2 o_soft_reset && !o_slow_osc_sel ##1 !o_soft_reset)
      else $error("software reset pulse wrong");
   pulse_single_a: assert property (
      o_link_pulse |-> o_mode == MODE_SLEEP ##1 !o_link_pulse)
      else $error("link pulse outside sleep or too long");
   energy_wake_a: assert property (
      o_mode == MODE_SLEEP && i_energy_detect |=> o_mode inside {MODE_ACTIVE, MODE_PDOWN})
      else $error("line energy did not wake");
   psave_seen_c: cover property (o_mode == MODE_PSAVE);
   sleep_pulse_c: cover property (o_mode == MODE_SLEEP && o_link_pulse);
   lowest_seen_c: cover property (o_lowest_power);
endmodule
bind phy_low_power_mode_control lp_mode_monitor #(
   .PULSE_GAP_CYCLES(PULSE_GAP_CYCLES),
   .LONG_GAP_FACTOR (LONG_GAP_FACTOR),
   .WAKE_HOLD_CYCLES(WAKE_HOLD_CYCLES)
) i_mon (.i_clock, .i_rst_n, .i_wr_en, .i_wr_reg, .i_wr_data, .i_autoneg_en, .i_link_up,
   .i_energy_detect, .o_rx_blocks_en, .o_tx_en, .o_energy_det_en, .o_pll_en,
   .o_ref_crystal_input_en, .o_slow_osc_sel, .o_mgmt_only, .o_lowest_power, .o_link_pulse,
   .o_soft_reset, .o_mode);
`default_nettype wire

// File: test_phy_low_power_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
// walks every low-power mode through the management write port
module test_phy_low_power_mode_control;
   import phy_lp_pkg::*;
   localparam int GAP  = 20; // short pulse gap keeps the run brief
   localparam int HOLD = 10; // short wake hold
   logic        i_clock, i_rst_n, i_wr_en, i_autoneg_en, i_link_up;
   logic        i_energy_detect, i_long_pulse_gap;
   logic [4:0]  i_wr_reg, i_rd_reg;
   logic [15:0] i_wr_data, o_rd_data;
   logic        o_rx_blocks_en, o_tx_en, o_energy_det_en, o_pll_en, o_ref_crystal_input_en;
   logic        o_slow_osc_sel, o_mgmt_only, o_lowest_power, o_link_pulse, o_soft_reset;
   lp_mode_t    o_mode;
   logic [7:0]  pwr;         // rx,tx,energy,pll,ref,slow,mgmt,lowest
   int          err_total;   // mismatches
   int          comparisons; // checks made
   int          pulses;      // link pulses in a window
   assign pwr = {o_rx_blocks_en, o_tx_en, o_energy_det_en, o_pll_en, o_ref_crystal_input_en,
                 o_slow_osc_sel, o_mgmt_only, o_lowest_power};
   phy_low_power_mode_control #(.PULSE_GAP_CYCLES(GAP), .LONG_GAP_FACTOR(4),
      .WAKE_HOLD_CYCLES(HOLD)) i_dut (.i_clock, .i_rst_n, .i_wr_en, .i_wr_reg, .i_wr_data,
      .i_rd_reg, .o_rd_data, .i_autoneg_en, .i_link_up, .i_energy_detect, .i_long_pulse_gap,
      .o_rx_blocks_en, .o_tx_en, .o_energy_det_en, .o_pll_en, .o_ref_crystal_input_en,
      .o_slow_osc_sel, .o_mgmt_only, .o_lowest_power, .o_link_pulse, .o_soft_reset, .o_mode);
   // 250 MHz clock
   initial i_clock = 1'b0;
   always #2 i_clock = ~i_clock;
   // one comparison, mismatch reported at once
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   // one write strobe; returns once the mode outputs have followed
   task automatic wr(input logic [4:0] r, input logic [15:0] d);
      @(negedge i_clock);
      i_wr_en   = 1'b1;
      i_wr_reg  = r;
      i_wr_data = d;
      @(negedge i_clock);
      i_wr_en = 1'b0;
      @(negedge i_clock);
   endtask
   // registered read, data one cycle after the number
   task automatic rd(input logic [4:0] r, input logic [15:0] exp);
      @(negedge i_clock);
      i_rd_reg = r;
      @(negedge i_clock);
      chk(o_rd_data, exp, "read data");
   endtask
   // bounded wait for a mode; a miss ends the run
   task automatic wait_mode(input lp_mode_t m);
      int n;
      n = 0;
      while (o_mode !== m && n < 60) begin
         @(negedge i_clock);
         n++;
      end
      chk(o_mode, m, "mode");
      if (o_mode !== m) results();
   endtask
   // counts one-cycle link pulses over a window
   task automatic count_pulses(input int cyc, input int exp);
      pulses = 0;
      repeat (cyc) begin
         @(negedge i_clock);
         if (o_link_pulse === 1'b1) pulses++;
      end
      chk(pulses[15:0], exp[15:0], "link pulse count");
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      #100000;
      err_total++;
      results();
   end
   initial begin
      err_total        = 0;
      comparisons      = 0;
      i_rst_n          = 1'b0;
      i_wr_en          = 1'b0;
      i_wr_reg         = 5'h00;
      i_wr_data        = 16'h0000;
      i_rd_reg         = 5'h00;
      i_autoneg_en     = 1'b1;
      i_link_up        = 1'b0;
      i_energy_detect  = 1'b0;
      i_long_pulse_gap = 1'b0;
      repeat (10) @(negedge i_clock);
      i_rst_n = 1'b1;
      chk(o_mode, MODE_ACTIVE, "mode after reset");
      chk(pwr, 8'hf8, "enables after reset");
      rd(REG_PHY_CTRL2, 16'h0000);
      rd(REG_SENSE_CTRL, 16'h0800);
      rd(REG_OSC_CTRL, 16'h0000);
      wr(5'h05, 16'hffff);
      rd(5'h05, 16'h0000);
      // power-saving only while negotiating without link
      wr(REG_PHY_CTRL2, 16'h0400);
      wait_mode(MODE_PSAVE);
      chk(pwr, 8'h78, "power-saving enables");
      rd(REG_PHY_CTRL2, 16'h0400);
      i_link_up = 1'b1;
      wait_mode(MODE_ACTIVE);
      i_link_up    = 1'b0;
      i_autoneg_en = 1'b0;
      wait_mode(MODE_ACTIVE);
      i_autoneg_en = 1'b1;
      wait_mode(MODE_PSAVE);
      // energy sense sleep outranks power-saving
      wr(REG_SENSE_CTRL, 16'h0000);
      wait_mode(MODE_SLEEP);
      count_pulses(50, 3);
      wr(REG_DIG_CTRL, 16'h0010);
      chk(pwr, 8'h68, "sleep with pll off");
      rd(REG_DIG_CTRL, 16'h0010);
      i_energy_detect = 1'b1;
      wait_mode(MODE_ACTIVE);
      chk(pwr, 8'hf8, "woken enables");
      // energy standing longer than the hold keeps the blocks up
      repeat (2 * HOLD) @(negedge i_clock);
      chk(o_mode, MODE_ACTIVE, "held awake while energy");
      i_energy_detect  = 1'b0;
      i_long_pulse_gap = 1'b1;
      wait_mode(MODE_SLEEP);
      count_pulses(50, 1);
      // software power-down, then slow oscillator on top
      wr(REG_BASIC_CTRL, 16'h0800);
      wait_mode(MODE_PDOWN);
      chk(pwr, 8'h0a, "power-down enables");
      rd(REG_BASIC_CTRL, 16'h0800);
      wr(REG_OSC_CTRL, 16'h0020);
      chk(pwr, 8'h07, "lowest power");
      rd(REG_OSC_CTRL, 16'h0020);
      // exit order: oscillator, power-down, software reset
      wr(REG_OSC_CTRL, 16'h0000);
      chk(pwr, 8'h0a, "crystal back");
      wr(REG_BASIC_CTRL, 16'h0000);
      chk(pwr, 8'h68, "power-down left");
      wr(REG_BASIC_CTRL, 16'h8000);
      pulses = 0;
      repeat (3) begin
         if (o_soft_reset === 1'b1) pulses++;
         @(negedge i_clock);
      end
      chk(pulses[15:0], 16'h0001, "software reset pulse");
      wait_mode(MODE_ACTIVE);
      rd(REG_SENSE_CTRL, 16'h0800);
      rd(REG_PHY_CTRL2, 16'h0000);
      rd(REG_DIG_CTRL, 16'h0000);
      chk(pwr, 8'hf8, "enables after software reset");
      results();
   end
endmodule
`default_nettype wire
